/* File: design/cfc_pkg.sv */
// Package for the CAN fault-confinement block: constants and carriers.
// Functional notes
// (RQ1) Count 96 or more sets warning bit; code 00 below 96, 01 to 127.
// (RQ2) Count 128 or more means error passive; code reads 11.
// (RQ3) Transmit count reaching 256 gives bus-off; counter never shows 256.
// (RQ4) Active node sends dominant flag; passive sends recessive plus suspend.
// (RQ5) Bus-off: no storing, but timestamp, receive count and valid go on.
// (RQ6) A +8 at transmit count 248..255 gives bus-off without incrementing.
// (RQ7) Receiver error adds 1 unless priority set or own active flag.
// (RQ8) Receiver seeing dominant after error flag adds 8.
// (RQ9) Transmitter sending error flag adds 8, except two listed cases.
// (RQ10) Bit error in own active or overload flag adds 8 by role.
// (RQ11) Long dominant runs after flags add 8 to the current role counter.
// (RQ12) Good transmission decrements transmit count, stopping at zero.
// (RQ13) Good reception decrements 1..127, or loads 119..126 with priority.
// (RQ14) Flag kind uses counts before the error; increment after flag sent.
// (RQ15) Bit error in intermission requests an overload frame.
// (RQ16) In bus-off the transmit pin stays recessive.
// (RQ17) Initialization request is taken at once; mode field reads 000.
// (RQ18) After bus-off, operation request waits for 128 recessive runs of 11.
// (RQ19) Re-entering initialization restarts the recessive run count.
// (RQ20) Sleep allowed in bus-off; leaving sleep starts recovery directly.
// (RQ21) Clear-counters with operation request skips recovery; join after 11.
// (RQ22) Clear-counters in initialization resets counters and state; self-clears.
// (RQ23) Recessive run detector restarts on dominant, counts at sample points.
package cfc_pkg;

	localparam logic [7:0] CFC_OFS_CTRL = 8'h00;
	localparam logic [7:0] CFC_OFS_ERRCNT = 8'h04;
	localparam logic [7:0] CFC_OFS_INFO = 8'h08;

	localparam int CFC_CTRL_MODE_LSB = 0;
	localparam int CFC_CTRL_GOM = 3;
	localparam int CFC_CTRL_CLEAR_COUNTERS_BIT = 4;
	localparam int CFC_CTRL_RX_ERROR_PRIORITY_SETTING = 5;
	localparam int CFC_CTRL_PS_LSB = 6;
	localparam int CFC_CTRL_PEND = 8;
	localparam int CFC_ERR_REC_LSB = 8;
	localparam int CFC_ERR_RPASS = 15;

	localparam logic [2:0] CFC_MODE_INIT = 3'h0;
	localparam logic [1:0] CFC_PS_NONE = 2'h0;
	localparam logic [7:0] CFC_WARN_LVL = 8'h60;
	localparam logic [7:0] CFC_PASS_LVL = 8'h80;
	localparam logic [7:0] CFC_BUS_OFF_FLAG_LVL = 8'hf8;
	localparam logic [7:0] CFC_REC_MAX = 8'h7f;
	localparam logic [7:0] CFC_RX_ERROR_PRIORITY_SETTING_LOAD = 8'h77;
	localparam logic [7:0] CFC_INC_BIG = 8'h08;
	localparam logic [7:0] CFC_INC_ONE = 8'h01;
	localparam logic [3:0] CFC_RUN_LEN = 4'hb;
	localparam logic [7:0] CFC_RUN_LAST = 8'h7f;

	typedef enum logic [1:0]
	{
		CFC_ST_INIT = 2'b00,
		CFC_ST_RECOVER = 2'b01,
		CFC_ST_OP = 2'b11,
		CFC_ST_JOIN = 2'b10
	} cfc_state_t;

	// Event pulses and levels from the protocol engine; each pulse lasts one clock cycle.
	typedef struct packed
	{
		logic sample_point;
		logic rx_bit;
		logic tx_bit;
		logic role_tx;
		logic err_rx;
		logic err_rx_dom_after_flag;
		logic err_tx_flag;
		logic exc_ack_passive;
		logic exc_stuff_arb;
		logic bit_err_active_flag;
		logic dom_seq_long;
		logic flag_done;
		logic tx_ok;
		logic rx_ok;
		logic bit_err_intermission;
		logic frame_valid;
		logic timestamp_toggle;
	} cfc_core_in_t;

	typedef struct packed
	{
		logic can_transmit_pin;
		logic error_flag_passive;
		logic overload_request;
		logic suspend_required;
		logic store_enable;
		logic frame_valid;
		logic timestamp_toggle_output;
		logic bus_off_flag;
	} cfc_core_out_t;

endpackage

/* File: design/cfc_fault_confinement.sv */
// CAN fault confinement: error counters, error states, bus-off recovery, APB.
`timescale 1ns/1ns
module cfc_fault_confinement
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire cfc_pkg::cfc_core_in_t core_in,
	output cfc_pkg::cfc_core_out_t     core_out
);
	import cfc_pkg::*;

	cfc_state_t    state_reg;
	logic [2:0]    mode_reg;
	logic [2:0]    pend_mode_reg;
	logic          gom_reg;
	logic          rx_error_priority_setting_reg;
	logic [1:0]    ps_reg;
	logic [7:0]    tx_error_count;
	logic [7:0]    rx_error_count;
	logic          bus_off_flag;
	logic [3:0]    run_cnt_reg;
	logic          run_done;
	logic          pend_tx8_reg;
	logic          pend_rx1_reg;
	logic          pend_rx8_reg;
	logic          access;
	logic          wr_ctrl;
	logic [2:0]    req_mode;
	logic [1:0]    req_ps;
	logic          req_clear_counters_bit;
	logic          init_refused;
	logic          sleep_exit;
	logic          recovery_done;
	logic          counting;
	logic          tx_add8;
	logic          rx_add8;
	logic          rx_add1;
	logic          tx_evt;
	logic          rx1_evt;
	logic          rx8_evt;
	logic          passive_now;
	logic [1:0]    tx_code;
	logic [1:0]    rx_code;
	logic [31:0]   rd_next;
	logic          addr_ok;

	// Two-bit status code: {passive, warning}.
	function automatic logic [1:0] err_code(input logic [7:0] cnt);
		err_code = {cnt >= CFC_PASS_LVL, cnt >= CFC_WARN_LVL};
	endfunction

	function automatic logic [7:0] sat_add(input logic [7:0] v,
		input logic [7:0] a);
		logic [8:0] s;
		s = {1'b0, v} + {1'b0, a};
		sat_add = s[8] ? 8'hff : s[7:0];
	endfunction

	assign access = psel & penable & ~pready;
	assign wr_ctrl = access & pwrite & (paddr == CFC_OFS_CTRL);
	assign req_mode = pwdata[CFC_CTRL_MODE_LSB +: 3];
	assign req_ps = pwdata[CFC_CTRL_PS_LSB +: 2];
	assign req_clear_counters_bit = pwdata[CFC_CTRL_CLEAR_COUNTERS_BIT];
	assign addr_ok = (paddr == CFC_OFS_CTRL) | (paddr == CFC_OFS_ERRCNT)
		| (paddr == CFC_OFS_INFO);

	// Outside recovery, a mode write of init with GOM kept set is not taken while a power-save mode is selected and the same write keeps one selected.
	assign init_refused = (ps_reg != CFC_PS_NONE) & (req_ps != CFC_PS_NONE); // RQ20

	// Leaving sleep in bus-off, by software or a dominant bus bit.
	assign sleep_exit = bus_off_flag & (ps_reg != CFC_PS_NONE)
		& (state_reg == CFC_ST_OP)
		& ((wr_ctrl & (req_ps == CFC_PS_NONE))
		| (core_in.sample_point & ~core_in.rx_bit)); // RQ20

	assign recovery_done = (state_reg == CFC_ST_RECOVER) & run_done
		& (rx_error_count == CFC_RUN_LAST); // RQ18

	assign counting = (state_reg == CFC_ST_OP) | (state_reg == CFC_ST_JOIN);

	// Recessive run detector; the count restarts on any dominant sample.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_cnt_reg <= 4'h0;
		else if (state_reg == CFC_ST_INIT && wr_ctrl)
			run_cnt_reg <= 4'h0; // RQ19
		else if (core_in.sample_point)
		begin
			if (!core_in.rx_bit || run_done)
				run_cnt_reg <= 4'h0; // RQ23
			else
				run_cnt_reg <= run_cnt_reg + 4'h1; // RQ23
		end
	end

	assign run_done = core_in.sample_point & core_in.rx_bit
		& (run_cnt_reg == CFC_RUN_LEN - 4'h1); // RQ23

	// Software settings held in the control register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gom_reg <= 1'b0;
			rx_error_priority_setting_reg <= 1'b0;
			ps_reg <= CFC_PS_NONE;
		end
		else if (wr_ctrl)
		begin
			gom_reg <= pwdata[CFC_CTRL_GOM];
			rx_error_priority_setting_reg <= pwdata[CFC_CTRL_RX_ERROR_PRIORITY_SETTING];
			ps_reg <= req_ps;
		end
	end

	// Operating mode sequencing and bus-off recovery.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= CFC_ST_INIT;
			mode_reg <= CFC_MODE_INIT;
			pend_mode_reg <= CFC_MODE_INIT;
		end
		else if (!gom_reg && state_reg != CFC_ST_INIT)
		begin
			state_reg <= CFC_ST_INIT;
			mode_reg <= CFC_MODE_INIT;
		end
		else
		begin
			unique case (state_reg)
				CFC_ST_INIT:
					if (wr_ctrl && pwdata[CFC_CTRL_GOM]
						&& req_mode != CFC_MODE_INIT)
					begin
						if (bus_off_flag && !req_clear_counters_bit)
						begin
							state_reg <= CFC_ST_RECOVER; // RQ18
							pend_mode_reg <= req_mode;
						end
						else if (bus_off_flag)
						begin
							state_reg <= CFC_ST_JOIN; // RQ21
							mode_reg <= req_mode;
						end
						else
						begin
							state_reg <= CFC_ST_OP;
							mode_reg <= req_mode;
						end
					end
				CFC_ST_RECOVER:
					if (wr_ctrl && req_mode == CFC_MODE_INIT)
						state_reg <= CFC_ST_INIT; // RQ19
					else if (recovery_done)
					begin
						state_reg <= CFC_ST_OP; // RQ18
						mode_reg <= pend_mode_reg;
					end
				CFC_ST_JOIN:
					if (wr_ctrl && req_mode == CFC_MODE_INIT && !init_refused)
					begin
						state_reg <= CFC_ST_INIT; // RQ17
						mode_reg <= CFC_MODE_INIT;
					end
					else if (run_done)
						state_reg <= CFC_ST_OP; // RQ21
				CFC_ST_OP:
					if (sleep_exit)
					begin
						state_reg <= CFC_ST_RECOVER; // RQ20
						pend_mode_reg <= mode_reg;
					end
					else if (wr_ctrl && req_mode == CFC_MODE_INIT
						&& !init_refused)
					begin
						state_reg <= CFC_ST_INIT; // RQ17
						mode_reg <= CFC_MODE_INIT;
					end
			endcase
		end
	end

	// Counter steps decided at the error are held until the flag is out.
	assign tx_evt = counting & ((core_in.err_tx_flag & ~core_in.exc_ack_passive
		& ~core_in.exc_stuff_arb)
		| (core_in.bit_err_active_flag & core_in.role_tx)); // RQ9 RQ10
	assign rx1_evt = counting & core_in.err_rx & ~rx_error_priority_setting_reg; // RQ7
	assign rx8_evt = counting & core_in.bit_err_active_flag
		& ~core_in.role_tx & ~rx_error_priority_setting_reg; // RQ10

	// A new event in the release cycle stays pending for the next flag.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_tx8_reg <= 1'b0;
			pend_rx1_reg <= 1'b0;
			pend_rx8_reg <= 1'b0;
		end
		else
		begin
			pend_tx8_reg <= tx_evt | (pend_tx8_reg & ~core_in.flag_done); // RQ14
			pend_rx1_reg <= rx1_evt | (pend_rx1_reg & ~core_in.flag_done); // RQ14
			pend_rx8_reg <= rx8_evt | (pend_rx8_reg & ~core_in.flag_done); // RQ14
		end
	end

	assign tx_add8 = counting & ((pend_tx8_reg & core_in.flag_done)
		| (core_in.dom_seq_long & core_in.role_tx)); // RQ11
	assign rx_add8 = counting & ~rx_error_priority_setting_reg
		& ((pend_rx8_reg & core_in.flag_done)
		| core_in.err_rx_dom_after_flag // RQ8
		| (core_in.dom_seq_long & ~core_in.role_tx)); // RQ11
	assign rx_add1 = pend_rx1_reg & core_in.flag_done & counting;

	// Error counters and bus-off flag.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_error_count <= 8'h00;
			rx_error_count <= 8'h00;
			bus_off_flag <= 1'b0;
		end
		else if (state_reg == CFC_ST_INIT && wr_ctrl && req_clear_counters_bit)
		begin
			tx_error_count <= 8'h00; // RQ22
			rx_error_count <= 8'h00; // RQ22
			bus_off_flag <= 1'b0; // RQ22
		end
		else if (state_reg == CFC_ST_INIT && wr_ctrl && bus_off_flag
			&& pwdata[CFC_CTRL_GOM] && req_mode != CFC_MODE_INIT)
			rx_error_count <= 8'h00; // RQ19
		else if (sleep_exit)
			rx_error_count <= 8'h00; // RQ20
		else if (state_reg == CFC_ST_RECOVER)
		begin
			if (recovery_done)
			begin
				tx_error_count <= 8'h00; // RQ18
				rx_error_count <= 8'h00;
				bus_off_flag <= 1'b0;
			end
			else if (run_done)
				rx_error_count <= rx_error_count + CFC_INC_ONE; // RQ18
		end
		else if (counting)
		begin
			// The transmit count is frozen while bus-off holds it invalid.
			if (tx_add8 && !bus_off_flag)
			begin
				if (tx_error_count >= CFC_BUS_OFF_FLAG_LVL)
					bus_off_flag <= 1'b1; // RQ3 RQ6
				else
					tx_error_count <= tx_error_count + CFC_INC_BIG; // RQ9
			end
			else if (core_in.tx_ok && !bus_off_flag
				&& tx_error_count != 8'h00)
				tx_error_count <= tx_error_count - CFC_INC_ONE; // RQ12
			if (rx_add8)
				rx_error_count <= sat_add(rx_error_count, CFC_INC_BIG); // RQ5
			else if (rx_add1)
				rx_error_count <= sat_add(rx_error_count, CFC_INC_ONE); // RQ7
			else if (core_in.rx_ok)
			begin
				if (rx_error_priority_setting_reg || rx_error_count > CFC_REC_MAX)
					rx_error_count <= CFC_RX_ERROR_PRIORITY_SETTING_LOAD; // RQ13
				else if (rx_error_count != 8'h00)
					rx_error_count <= rx_error_count - CFC_INC_ONE; // RQ13
			end
		end
	end

	assign passive_now = (tx_error_count >= CFC_PASS_LVL)
		| (rx_error_count >= CFC_PASS_LVL);
	assign tx_code = bus_off_flag ? 2'h3 : err_code(tx_error_count); // RQ1 RQ2
	assign rx_code = err_code(rx_error_count); // RQ1 RQ2

	// Protocol-facing outputs, all registered.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			core_out <= '{can_transmit_pin: 1'b1, default: 1'b0};
		else
		begin
			core_out.can_transmit_pin <= (bus_off_flag
				|| state_reg != CFC_ST_OP) ? 1'b1 : core_in.tx_bit; // RQ16
			// Sampled from the counts as they stand before this error.
			if (tx_evt || rx1_evt || rx8_evt || core_in.err_rx
				|| core_in.err_tx_flag)
				core_out.error_flag_passive <= passive_now; // RQ4 RQ14
			core_out.overload_request <= core_in.bit_err_intermission
				& counting; // RQ15
			core_out.suspend_required <= passive_now & ~bus_off_flag; // RQ4
			core_out.store_enable <= counting & ~bus_off_flag; // RQ5
			core_out.frame_valid <= core_in.frame_valid; // RQ5
			core_out.timestamp_toggle_output <= core_in.timestamp_toggle; // RQ5
			core_out.bus_off_flag <= bus_off_flag; // RQ3
		end
	end

	always_comb
	begin
		rd_next = 32'h0000_0000;
		unique case (paddr)
			CFC_OFS_CTRL:
			begin
				// Mode field shows init until a pending request completes.
				rd_next[CFC_CTRL_MODE_LSB +: 3] = (state_reg == CFC_ST_INIT
					|| state_reg == CFC_ST_RECOVER) ? CFC_MODE_INIT
					: mode_reg; // RQ17
				rd_next[CFC_CTRL_GOM] = gom_reg;
				rd_next[CFC_CTRL_RX_ERROR_PRIORITY_SETTING] = rx_error_priority_setting_reg;
				rd_next[CFC_CTRL_PS_LSB +: 2] = ps_reg;
				rd_next[CFC_CTRL_PEND] = state_reg == CFC_ST_RECOVER;
			end
			CFC_OFS_ERRCNT:
			begin
				rd_next[7:0] = tx_error_count;
				rd_next[CFC_ERR_REC_LSB +: 7] = rx_error_count[6:0];
				rd_next[CFC_ERR_RPASS] = rx_error_count >= CFC_PASS_LVL;
			end
			CFC_OFS_INFO:
				rd_next[4:0] = {bus_off_flag, tx_code, rx_code};
			default:
				rd_next = 32'h0000_0000;
		endcase
	end

	// APB slave with one wait state; unmapped addresses answer with pslverr.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			pslverr <= access & ~addr_ok;
			prdata <= (access && !pwrite) ? rd_next : 32'h0000_0000;
		end
	end

endmodule

/* File: tb/cfc_fault_confinement_monitor.sv */
// Checker for the fault-confinement block, bound to its ports.
`timescale 1ns/1ns
module cfc_fault_confinement_monitor
(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire cfc_pkg::cfc_core_in_t core_in,
	input wire cfc_pkg::cfc_core_out_t core_out
);
	import cfc_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence acc_s;
		psel && penable && !pready;
	endsequence
	sequence answer_s;
		pready ##1 !pready;
	endsequence
	sequence info_rd_s;
		pready && !pwrite && paddr == CFC_OFS_INFO;
	endsequence
	rdy_pulse_a: assert property (acc_s |=> answer_s)
		else $error("pready not a one-cycle answer");
	err_only_a: assert property (pslverr |-> pready)
		else $error("pslverr outside an answer");
	unmapped_zero_a: assert property (pready && paddr != CFC_OFS_CTRL
		&& paddr != CFC_OFS_ERRCNT && paddr != CFC_OFS_INFO
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	state_code_a: assert property (
		info_rd_s |-> prdata[1:0] != 2'b10 && prdata[3:2] != 2'b10)
		else $error("illegal error state code");
	bus_off_flag_code_a: assert property (info_rd_s ##0 prdata[4] |-> prdata[3])
		else $error("bus-off without passive transmit code");
	bus_off_flag_recessive_a: assert property (
		core_out.bus_off_flag |-> core_out.can_transmit_pin)
		else $error("transmit pin dominant in bus-off");
	ts_follow_a: assert property ($past(presetn) |=>
		core_out.timestamp_toggle_output == $past(core_in.timestamp_toggle))
		else $error("timestamp toggle not passed on");
	valid_follow_a: assert property ($past(presetn) |=>
		core_out.frame_valid == $past(core_in.frame_valid))
		else $error("frame valid not passed on");
	bus_off_flag_nostore_a: assert property (
		core_out.bus_off_flag && $past(core_out.bus_off_flag)
		|-> !core_out.store_enable)
		else $error("storing enabled in bus-off");
	ovl_req_a: assert property (
		core_in.bit_err_intermission && core_out.store_enable
		|=> core_out.overload_request)
		else $error("no overload request after intermission error");
endmodule

bind cfc_fault_confinement cfc_fault_confinement_monitor i_mon
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.core_in(core_in),
	.core_out(core_out)
);

/* File: tb/cfc_bus_node.sv */
// Behavioural far side: the other nodes as seen through the transceiver.
`timescale 1ns/1ns
module cfc_bus_node
#(
	parameter int SP = 4
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic can_transmit_pin,
	input  wire logic other_dom,
	output logic      sample_point,
	output logic      rx_bit
);
	logic [7:0] cnt_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_reg <= 8'h00;
		else
			cnt_reg <= (cnt_reg == 8'(SP - 1)) ? 8'h00 : cnt_reg + 8'h01;
	end
	assign sample_point = (cnt_reg == 8'(SP - 1));
	// Wired-AND bus; between sample points the level means nothing, so it
	// toggles rather than repeating the last bit.
	assign rx_bit = sample_point ? (can_transmit_pin & ~other_dom)
		: cnt_reg[0];
endmodule

/* File: tb/tb_can_fault_confinement.sv */
// Self-checking bench for the fault-confinement block.
`timescale 1ns/1ns
module tb_can_fault_confinement;
	import cfc_pkg::*;
	localparam int SP = 4;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic [16:0]   pulse_v = 17'h0;
	logic          role = 1'b1;
	logic          other_dom = 1'b0;
	logic [1:0]    rnd2 = 2'h0;
	logic          sp;
	logic          rxb;
	logic [63:0]   e_now;
	logic [63:0]   exp_q[$];
	cfc_core_in_t  core_in;
	cfc_core_out_t core_out;
	int            bad_count = 0;
	int            checks = 0;

	always #10 pclk = ~pclk;
	always_comb
	begin
		core_in = cfc_core_in_t'(pulse_v);
		core_in.sample_point = sp;
		core_in.rx_bit = rxb;
		core_in.tx_bit = 1'b0;
		core_in.role_tx = role;
		core_in.frame_valid = rnd2[1];
		core_in.timestamp_toggle = rnd2[0];
	end
	always @(posedge pclk)
		rnd2 <= 2'($urandom);

	cfc_fault_confinement i_dut
	(
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_in(core_in),
		.core_out(core_out)
	);
	cfc_bus_node #(.SP(SP)) i_bus
	(
		.pclk(pclk), .presetn(presetn),
		.can_transmit_pin(core_out.can_transmit_pin),
		.other_dom(other_dom), .sample_point(sp), .rx_bit(rxb)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			bad_count++;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps a following call from driving psel twice.
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		exp_q.push_back({m, e & m});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic pulse(input logic [16:0] m);
		pulse_v <= m;
		@(posedge pclk);
		pulse_v <= 17'h0;
		@(posedge pclk);
	endtask
	task automatic close_out;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Read answers are matched against the oldest note in the queue.
	always @(posedge pclk)
		if (pready === 1'b1 && !pwrite && exp_q.size() > 0)
		begin
			e_now = exp_q.pop_front();
			chk(prdata & e_now[63:32], e_now[31:0]);
		end

	initial
	begin
		#1000000;
		bad_count++;
		close_out();
	end

	initial
	begin
		void'($urandom(17833));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 16; a += 4)
			rd(8'(a), 32'h0, 32'hffffffff);
		apb(1'b1, CFC_OFS_CTRL, 32'h9);
		rd(CFC_OFS_CTRL, 32'h1, 32'h107);
		pulse(17'h10);
		rd(CFC_OFS_ERRCNT, 32'h0, 32'hff);
		pulse(17'h4);
		for (int i = 0; i < 32; i++)
		begin
			if (i == 20)
			begin
				pulse(17'h600);
				pulse(17'h20);
				pulse(17'h500);
				pulse(17'h20);
				rd(CFC_OFS_ERRCNT, 32'ha0, 32'hff);
			end
			pulse(17'h400);
			chk({31'h0, core_out.error_flag_passive}, 32'(i >= 16));
			pulse(17'h20);
			case (i)
				10: rd(CFC_OFS_INFO, 32'h0, 32'hff);
				11: rd(CFC_OFS_INFO, 32'h4, 32'hff);
				15: rd(CFC_OFS_INFO, 32'hc, 32'hff);
				30: rd(CFC_OFS_ERRCNT, 32'hf8, 32'hffff);
				31: rd(CFC_OFS_INFO, 32'h1c, 32'hff);
				default: ;
			endcase
		end
		chk({31'h0, core_out.can_transmit_pin}, 32'h1);
		apb(1'b1, CFC_OFS_CTRL, 32'h8);
		rd(CFC_OFS_CTRL, 32'h0, 32'h7);
		apb(1'b1, CFC_OFS_CTRL, 32'h9);
		rd(CFC_OFS_CTRL, 32'h100, 32'h107);
		repeat (30 * 11 * SP) @(posedge pclk);
		rd(CFC_OFS_INFO, 32'h10, 32'h10);
		apb(1'b1, CFC_OFS_CTRL, 32'h8);
		apb(1'b1, CFC_OFS_CTRL, 32'h9);
		rd(CFC_OFS_ERRCNT, 32'h0, 32'h7f00);
		repeat (128 * 11 * SP + 40) @(posedge pclk);
		rd(CFC_OFS_CTRL, 32'h1, 32'h107);
		rd(CFC_OFS_INFO, 32'h0, 32'hff);
		role <= 1'b0;
		pulse(17'h1000);
		pulse(17'h20);
		pulse(17'h800);
		pulse(17'h40);
		pulse(17'h80);
		pulse(17'h20);
		pulse(17'h8);
		rd(CFC_OFS_ERRCNT, 32'h1800, 32'hff00);
		apb(1'b1, CFC_OFS_CTRL, 32'h19);
		rd(CFC_OFS_ERRCNT, 32'h1800, 32'hff00);
		apb(1'b1, CFC_OFS_CTRL, 32'h8);
		apb(1'b1, CFC_OFS_CTRL, 32'h18);
		rd(CFC_OFS_CTRL, 32'h8, 32'h17);
		rd(CFC_OFS_ERRCNT, 32'h0, 32'hffff);
		role <= 1'b1;
		apb(1'b1, CFC_OFS_CTRL, 32'h9);
		repeat (32)
		begin
			pulse(17'h400);
			pulse(17'h20);
		end
		apb(1'b1, CFC_OFS_CTRL, 32'h8);
		apb(1'b1, CFC_OFS_CTRL, 32'h19);
		repeat (11 * SP + 20) @(posedge pclk);
		rd(CFC_OFS_CTRL, 32'h1, 32'h107);
		rd(CFC_OFS_INFO, 32'h0, 32'hff);
		chk({31'h0, core_out.can_transmit_pin}, 32'h0);
		close_out();
	end
endmodule
